// ---- pbmc_consts.vh ----
/*
 constants for the push-button message control block: timing figures,
 blink counts, state codes and indication selectors.
 assumes a 20 MHz system clock and inclusion by the design files only.
*/
// Summary of operation
// - a play pulse plays the message at the pointer, stopping at its end
// - another play pulse stops edge playback; pointer stays at that message start
// - led flashes during edge playback and goes off when it ends
// - held play loops messages, stepping forward after each, led flashing
// - releasing held play finishes the message and keeps pointer at its start
// - without clips, step blinks once with period one, twice after last message
// - with clips, step plays clip one, or clip two after last; clip length
// - play is ignored while record, erase or forward is busy
// - forward pulse advances the pointer, wrapping from last to first
// - idle forward not at last: advance, one blink or clip one
// - idle forward at last: wrap to first, two blinks or clip two
// - forward during play halts, steps, indicates, then plays new message
// - forward is ignored while erase or record is busy
// - short erase removes a message only when it is first or last
// - allowed erase deletes, two blinks or clip two, pointer to new end
// - refused erase deletes nothing, three blinks or clip three
// - erase during playback stops it, then acts as allowed or refused erase
// - erase held over 2.5 s starts global erase, clips kept
// - without clips, seven blinks; release within first three abandons
// - with clips, clip one three times; release before third abandons
// - still held after warning: erase all, then clip four with flashing if clip four is present
// - erase ignored during record or forward; during play deletes first/last
// - no button command is taken while an indication is running
`ifndef PBMC_CONSTS_VH
`define PBMC_CONSTS_VH

`define PBMC_CLK_KHZ 20000
`define PBMC_HOLD_MS 2500
`define PBMC_FLASH_MS 100
`define PBMC_PLAIN_ONE_MS 300
`define PBMC_PLAIN_TWO_MS 300
`define PBMC_PLAIN_THREE_MS 300
`define PBMC_PLAIN_FOUR_MS 500

`define PBMC_CNT_W 26
`define PBMC_ONE_BLINK 3'h1
`define PBMC_TWO_BLINKS 3'h2
`define PBMC_THREE_BLINKS 3'h3
`define PBMC_FOUR_BLINKS 3'h4

`define PBMC_SEL_ONE 2'h0
`define PBMC_SEL_TWO 2'h1
`define PBMC_SEL_THREE 2'h2
`define PBMC_SEL_FOUR 2'h3

`define PBMC_ST_IDLE 3'h0
`define PBMC_ST_PLAY 3'h1
`define PBMC_ST_IND 3'h2
`define PBMC_ST_EWAIT 3'h3
`define PBMC_ST_GHOLD 3'h4
`define PBMC_ST_WARN 3'h5
`define PBMC_ST_GERASE 3'h6

`endif

// ---- pbmc_blinker.v ----
/*
 led blink sequencer: a burst of plain blinks of a given period, or a
 flashing led that lasts until the sound clip reports its end.
 assumes start_i is a one-cycle pulse and flash_tick_i a one-cycle enable.
*/
`timescale 1ns/1ps
`include "pbmc_consts.vh"

module pbmc_blinker
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // request
   input wire start_i,
   input wire [2:0] count_i,
   input wire [`PBMC_CNT_W-1:0] period_i,
   input wire clip_mode_i,
   input wire clip_done_i,
   input wire flash_tick_i,
   // result
   output wire led_o,
   output wire done_o
);

reg run_ff;
reg clip_ff;
reg led_ff;
reg done_ff;
reg [2:0] left_ff;
reg [`PBMC_CNT_W-1:0] per_ff;
reg [`PBMC_CNT_W-1:0] cnt_ff;

assign led_o = led_ff;
assign done_o = done_ff;

always @(posedge sys_clk_i)
begin
   if (!rst_n_i)
   begin
      run_ff <= 1'b0;
      clip_ff <= 1'b0;
      led_ff <= 1'b0;
      done_ff <= 1'b0;
      left_ff <= 3'h0;
      per_ff <= {`PBMC_CNT_W{1'b0}};
      cnt_ff <= {`PBMC_CNT_W{1'b0}};
   end
   else
   begin
      done_ff <= 1'b0;
      if (start_i)
      begin
         run_ff <= 1'b1;
         clip_ff <= clip_mode_i;
         left_ff <= count_i;
         per_ff <= period_i;
         cnt_ff <= {`PBMC_CNT_W{1'b0}};
         led_ff <= 1'b1;
      end
      else if (run_ff && clip_ff)
      begin
         // blink length follows the recorded clip
         if (clip_done_i)
         begin
            run_ff <= 1'b0;
            led_ff <= 1'b0;
            done_ff <= 1'b1;
         end
         else if (flash_tick_i)
            led_ff <= ~led_ff;
      end
      else if (run_ff)
      begin
         if (cnt_ff == per_ff - 1'b1)
         begin
            cnt_ff <= {`PBMC_CNT_W{1'b0}};
            if (left_ff == `PBMC_ONE_BLINK)
            begin
               run_ff <= 1'b0;
               led_ff <= 1'b0;
               done_ff <= 1'b1;
            end
            else
            begin
               left_ff <= left_ff - 1'b1;
               led_ff <= 1'b1;
            end
         end
         else
         begin
            cnt_ff <= cnt_ff + 1'b1;
            if (cnt_ff == (per_ff >> 1))
               led_ff <= 1'b0;
         end
      end
   end
end

endmodule // pbmc_blinker

// ---- pbmc_ctrl.v ----
/*
 push-button message control: play, forward, single and global erase
 commands, led patterns and sound clip requests.
 assumes debounced active-low buttons from pins and a memory manager that
 plays, steps, erases, moves the pointer and reports first/last flags.
*/
`timescale 1ns/1ps
`include "pbmc_consts.vh"

module pbmc_ctrl #(
   parameter HOLD_CYC = `PBMC_HOLD_MS * `PBMC_CLK_KHZ,
   parameter FLASH_CYC = `PBMC_FLASH_MS * `PBMC_CLK_KHZ,
   parameter PLAIN_ONE_CYC = `PBMC_PLAIN_ONE_MS * `PBMC_CLK_KHZ,
   parameter PLAIN_TWO_CYC = PLAIN_ONE_CYC * `PBMC_PLAIN_TWO_MS / `PBMC_PLAIN_ONE_MS,
   parameter PLAIN_THREE_CYC = `PBMC_PLAIN_THREE_MS * `PBMC_CLK_KHZ,
   parameter PLAIN_FOUR_CYC = `PBMC_PLAIN_FOUR_MS * `PBMC_CLK_KHZ
)
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // buttons, active low, debounced
   input wire play_button_n_i,
   input wire forward_button_n_i,
   input wire erase_button_n_i,
   // memory manager status
   input wire record_busy_i,
   input wire msg_first_i,
   input wire msg_last_i,
   input wire play_done_i,
   input wire erase_done_i,
   input wire [3:0] clip_present_i,
   input wire clip_done_i,
   // memory manager commands
   output reg play_start_o,
   output reg play_stop_o,
   output reg ptr_fwd_o,
   output reg erase_msg_o,
   output reg erase_all_o,
   output reg clip_play_o,
   output reg [1:0] clip_sel_o,
   // indication
   output wire led_o,
   output wire busy_o
);

localparam [`PBMC_CNT_W-1:0] HOLD_C = HOLD_CYC[`PBMC_CNT_W-1:0];
localparam [`PBMC_CNT_W-1:0] FLASH_C = FLASH_CYC[`PBMC_CNT_W-1:0];
localparam [`PBMC_CNT_W-1:0] P1_C = PLAIN_ONE_CYC[`PBMC_CNT_W-1:0];
localparam [`PBMC_CNT_W-1:0] P2_C = PLAIN_TWO_CYC[`PBMC_CNT_W-1:0];
localparam [`PBMC_CNT_W-1:0] P3_C = PLAIN_THREE_CYC[`PBMC_CNT_W-1:0];
localparam [`PBMC_CNT_W-1:0] P4_C = PLAIN_FOUR_CYC[`PBMC_CNT_W-1:0];

// button synchronisers and edge history
reg [2:0] btn_s1_ff;
reg [2:0] btn_s2_ff;
reg [2:0] btn_prev_ff;
wire play_low = ~btn_s2_ff[0];
wire fwd_low = ~btn_s2_ff[1];
wire erase_low = ~btn_s2_ff[2];
wire play_fall = btn_prev_ff[0] & ~btn_s2_ff[0];
wire fwd_fall = btn_prev_ff[1] & ~btn_s2_ff[1];
wire erase_fall = btn_prev_ff[2] & ~btn_s2_ff[2];

reg [2:0] state_ff;
reg [2:0] nxt_state;
reg [2:0] ret_ff;
reg [2:0] nxt_ret;
reg [1:0] ind_sel_ff;
reg [1:0] nxt_ind_sel;
reg [2:0] ind_cnt_ff;
reg [2:0] nxt_ind_cnt;
reg ind_go_ff;
reg nxt_ind_go;
reg [1:0] warn_ff;
reg [1:0] nxt_warn;
reg [`PBMC_CNT_W-1:0] hold_cnt_ff;
reg [`PBMC_CNT_W-1:0] flash_cnt_ff;
reg flash_led_ff;
reg nxt_play_start;
reg nxt_play_stop;
reg nxt_ptr_fwd;
reg nxt_erase_msg;
reg nxt_erase_all;
reg nxt_clip_play;

wire flash_tick = (flash_cnt_ff == FLASH_C - 1'b1);
wire hold_reached = (hold_cnt_ff >= HOLD_C);
wire clips_on = clip_present_i[`PBMC_SEL_ONE];
wire blk_led;
wire blk_done;
reg [`PBMC_CNT_W-1:0] ind_per;

always @*
begin
   case (ind_sel_ff)
      `PBMC_SEL_ONE: ind_per = P1_C;
      `PBMC_SEL_TWO: ind_per = P2_C;
      `PBMC_SEL_THREE: ind_per = P3_C;
      default: ind_per = P4_C;
   endcase
end

pbmc_blinker u_blinker
(
   .sys_clk_i(sys_clk_i),
   .rst_n_i(rst_n_i),
   .start_i(ind_go_ff),
   .count_i(ind_cnt_ff),
   .period_i(ind_per),
   .clip_mode_i(clip_present_i[ind_sel_ff]),
   .clip_done_i(clip_done_i),
   .flash_tick_i(flash_tick),
   .led_o(blk_led),
   .done_o(blk_done)
);

// led flashes while playing; indications drive it otherwise
assign led_o = (state_ff == `PBMC_ST_PLAY) ? flash_led_ff :
               (state_ff == `PBMC_ST_IND || state_ff == `PBMC_ST_WARN) ? blk_led : 1'b0;
assign busy_o = (state_ff != `PBMC_ST_IDLE);

always @*
begin
   nxt_state = state_ff;
   nxt_ret = ret_ff;
   nxt_ind_sel = ind_sel_ff;
   nxt_ind_cnt = ind_cnt_ff;
   nxt_ind_go = 1'b0;
   nxt_warn = warn_ff;
   nxt_play_start = 1'b0;
   nxt_play_stop = 1'b0;
   nxt_ptr_fwd = 1'b0;
   nxt_erase_msg = 1'b0;
   nxt_erase_all = 1'b0;
   nxt_clip_play = 1'b0;
   case (state_ff)
      `PBMC_ST_IDLE:
      begin
         if (record_busy_i)
            nxt_state = `PBMC_ST_IDLE;
         else if (erase_fall)
         begin
            if (msg_first_i || msg_last_i)
            begin
               nxt_erase_msg = 1'b1;
               nxt_state = `PBMC_ST_EWAIT;
            end
            else
            begin
               nxt_ind_sel = `PBMC_SEL_THREE;
               nxt_ind_cnt = `PBMC_THREE_BLINKS;
               nxt_ind_go = 1'b1;
               nxt_ret = `PBMC_ST_GHOLD;
               nxt_state = `PBMC_ST_IND;
            end
         end
         else if (fwd_fall)
         begin
            nxt_ptr_fwd = 1'b1;
            nxt_ind_sel = msg_last_i ? `PBMC_SEL_TWO : `PBMC_SEL_ONE;
            nxt_ind_cnt = msg_last_i ? `PBMC_TWO_BLINKS : `PBMC_ONE_BLINK;
            nxt_ind_go = 1'b1;
            nxt_ret = `PBMC_ST_IDLE;
            nxt_state = `PBMC_ST_IND;
         end
         else if (play_fall)
         begin
            nxt_play_start = 1'b1;
            nxt_state = `PBMC_ST_PLAY;
         end
      end
      `PBMC_ST_PLAY:
      begin
         if (erase_fall)
         begin
            nxt_play_stop = 1'b1;
            if (msg_first_i || msg_last_i)
            begin
               nxt_erase_msg = 1'b1;
               nxt_state = `PBMC_ST_EWAIT;
            end
            else
            begin
               nxt_ind_sel = `PBMC_SEL_THREE;
               nxt_ind_cnt = `PBMC_THREE_BLINKS;
               nxt_ind_go = 1'b1;
               nxt_ret = `PBMC_ST_GHOLD;
               nxt_state = `PBMC_ST_IND;
            end
         end
         else if (fwd_fall)
         begin
            nxt_play_stop = 1'b1;
            nxt_ptr_fwd = 1'b1;
            nxt_ind_sel = msg_last_i ? `PBMC_SEL_TWO : `PBMC_SEL_ONE;
            nxt_ind_cnt = msg_last_i ? `PBMC_TWO_BLINKS : `PBMC_ONE_BLINK;
            nxt_ind_go = 1'b1;
            nxt_ret = `PBMC_ST_PLAY;
            nxt_state = `PBMC_ST_IND;
         end
         else if (play_fall)
         begin
            nxt_play_stop = 1'b1;
            nxt_state = `PBMC_ST_IDLE;
         end
         else if (play_done_i)
         begin
            if (play_low)
            begin
               nxt_ptr_fwd = 1'b1;
               nxt_ind_sel = msg_last_i ? `PBMC_SEL_TWO : `PBMC_SEL_ONE;
               nxt_ind_cnt = msg_last_i ? `PBMC_TWO_BLINKS : `PBMC_ONE_BLINK;
               nxt_ind_go = 1'b1;
               nxt_ret = `PBMC_ST_PLAY;
               nxt_state = `PBMC_ST_IND;
            end
            else
               nxt_state = `PBMC_ST_IDLE;
         end
      end
      `PBMC_ST_IND:
      begin
         // buttons are not looked at until the indication ends
         if (blk_done)
         begin
            nxt_state = ret_ff;
            if (ret_ff == `PBMC_ST_PLAY)
               nxt_play_start = 1'b1;
         end
      end
      `PBMC_ST_EWAIT:
      begin
         if (erase_done_i)
         begin
            nxt_ind_sel = `PBMC_SEL_TWO;
            nxt_ind_cnt = `PBMC_TWO_BLINKS;
            nxt_ind_go = 1'b1;
            nxt_ret = `PBMC_ST_GHOLD;
            nxt_state = `PBMC_ST_IND;
         end
      end
      `PBMC_ST_GHOLD:
      begin
         if (!erase_low)
            nxt_state = `PBMC_ST_IDLE;
         else if (hold_reached)
         begin
            nxt_warn = 2'h0;
            nxt_ind_sel = `PBMC_SEL_ONE;
            nxt_ind_cnt = clips_on ? `PBMC_ONE_BLINK : `PBMC_THREE_BLINKS;
            nxt_ind_go = 1'b1;
            nxt_state = `PBMC_ST_WARN;
         end
      end
      `PBMC_ST_WARN:
      begin
         if (clips_on && blk_done)
         begin
            if (warn_ff == 2'h2)
            begin
               nxt_erase_all = 1'b1;
               nxt_state = `PBMC_ST_GERASE;
            end
            else if (!erase_low)
               nxt_state = `PBMC_ST_IDLE;
            else
            begin
               nxt_warn = warn_ff + 1'b1;
               nxt_ind_go = 1'b1;
            end
         end
         else if (blk_done)
         begin
            if (warn_ff != 2'h0)
            begin
               nxt_erase_all = 1'b1;
               nxt_state = `PBMC_ST_GERASE;
            end
            else if (!erase_low)
               nxt_state = `PBMC_ST_IDLE;
            else
            begin
               nxt_warn = 2'h1;
               nxt_ind_sel = `PBMC_SEL_FOUR;
               nxt_ind_cnt = `PBMC_FOUR_BLINKS;
               nxt_ind_go = 1'b1;
            end
         end
      end
      `PBMC_ST_GERASE:
      begin
         if (erase_done_i)
         begin
            if (clip_present_i[`PBMC_SEL_FOUR])
            begin
               nxt_ind_sel = `PBMC_SEL_FOUR;
               nxt_ind_cnt = `PBMC_FOUR_BLINKS;
               nxt_ind_go = 1'b1;
               nxt_ret = `PBMC_ST_IDLE;
               nxt_state = `PBMC_ST_IND;
            end
            else
               nxt_state = `PBMC_ST_IDLE;
         end
      end
      default:
         nxt_state = `PBMC_ST_IDLE;
   endcase
   // a clip accompanies each indication whose clip is programmed
   if (nxt_ind_go && clip_present_i[nxt_ind_sel])
      nxt_clip_play = 1'b1;
end

always @(posedge sys_clk_i)
begin
   if (!rst_n_i)
   begin
      btn_s1_ff <= 3'h7;
      btn_s2_ff <= 3'h7;
      btn_prev_ff <= 3'h7;
      state_ff <= `PBMC_ST_IDLE;
      ret_ff <= `PBMC_ST_IDLE;
      ind_sel_ff <= `PBMC_SEL_ONE;
      ind_cnt_ff <= `PBMC_ONE_BLINK;
      ind_go_ff <= 1'b0;
      warn_ff <= 2'h0;
      hold_cnt_ff <= {`PBMC_CNT_W{1'b0}};
      flash_cnt_ff <= {`PBMC_CNT_W{1'b0}};
      flash_led_ff <= 1'b0;
      play_start_o <= 1'b0;
      play_stop_o <= 1'b0;
      ptr_fwd_o <= 1'b0;
      erase_msg_o <= 1'b0;
      erase_all_o <= 1'b0;
      clip_play_o <= 1'b0;
      clip_sel_o <= `PBMC_SEL_ONE;
   end
   else
   begin
      btn_s1_ff <= {erase_button_n_i, forward_button_n_i, play_button_n_i};
      btn_s2_ff <= btn_s1_ff;
      btn_prev_ff <= btn_s2_ff;
      state_ff <= nxt_state;
      ret_ff <= nxt_ret;
      ind_sel_ff <= nxt_ind_sel;
      ind_cnt_ff <= nxt_ind_cnt;
      ind_go_ff <= nxt_ind_go;
      warn_ff <= nxt_warn;
      // continuous-hold timer for global erase, saturating
      if (!erase_low)
         hold_cnt_ff <= {`PBMC_CNT_W{1'b0}};
      else if (!hold_reached)
         hold_cnt_ff <= hold_cnt_ff + 1'b1;
      if (flash_tick)
      begin
         flash_cnt_ff <= {`PBMC_CNT_W{1'b0}};
         flash_led_ff <= ~flash_led_ff;
      end
      else
         flash_cnt_ff <= flash_cnt_ff + 1'b1;
      play_start_o <= nxt_play_start;
      play_stop_o <= nxt_play_stop;
      ptr_fwd_o <= nxt_ptr_fwd;
      erase_msg_o <= nxt_erase_msg;
      erase_all_o <= nxt_erase_all;
      clip_play_o <= nxt_clip_play;
      if (nxt_ind_go)
         clip_sel_o <= nxt_ind_sel;
   end
end

endmodule // pbmc_ctrl

// ---- pbmc_ctrl_sva.sv ----
/*
 port assertions for the push-button message control.
 assumes binding to pbmc_ctrl, hold count handed on from it.
*/
`timescale 1ns/1ps

module pbmc_ctrl_sva #(
   parameter HOLD_CYC = 200
)
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // buttons and manager status
   input wire play_button_n_i,
   input wire forward_button_n_i,
   input wire erase_button_n_i,
   input wire record_busy_i,
   input wire msg_first_i,
   input wire msg_last_i,
   input wire play_done_i,
   input wire [3:0] clip_present_i,
   // commands and indication
   input wire play_start_o,
   input wire ptr_fwd_o,
   input wire erase_msg_o,
   input wire erase_all_o,
   input wire clip_play_o,
   input wire [1:0] clip_sel_o,
   input wire led_o,
   input wire busy_o
);
   reg [31:0] hold_ff;
   wire [31:0] nxt_hold = erase_button_n_i ? 32'h0 : hold_ff + 32'h1;
   wire idle_w = !busy_o && !record_busy_i && play_button_n_i && erase_button_n_i;

   // pin-level erase hold length
   always @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
         hold_ff <= 32'h0;
      else
         hold_ff <= nxt_hold;
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   fwd_taken_a: assert property ($fell(forward_button_n_i) && idle_w |-> ##[3:5] ptr_fwd_o)
      else $error("forward press not taken");
   rec_block_a: assert property ((record_busy_i && !busy_o) [*5] |-> !(ptr_fwd_o || play_start_o || erase_msg_o))
      else $error("command issued during record");
   erase_end_a: assert property (erase_msg_o |-> msg_first_i || msg_last_i)
      else $error("middle message erased");
   led_idle_a: assert property (!busy_o |-> !led_o)
      else $error("led lit while idle");
   clip_step_a: assert property (ptr_fwd_o && !msg_last_i && clip_present_i[0] |-> ##[0:2] (clip_play_o && clip_sel_o == 2'h0))
      else $error("step clip missing");
   clip_wrap_a: assert property (ptr_fwd_o && msg_last_i && clip_present_i[1] |-> ##[0:2] (clip_play_o && clip_sel_o == 2'h1))
      else $error("wrap clip missing");
   hold_time_a: assert property (erase_all_o |-> hold_ff >= HOLD_CYC)
      else $error("global erase before hold time");
   still_held_a: assert property (erase_all_o |-> !$past(erase_button_n_i, 6))
      else $error("global erase after release");
   play_busy_a: assert property (play_start_o |-> busy_o ##1 busy_o)
      else $error("play start without busy");
   play_end_a: assert property (play_button_n_i [*4] ##1 (play_done_i && busy_o) |-> ##[1:3] (!busy_o && !led_o))
      else $error("playback did not end");

   cover property (erase_all_o);
   cover property (clip_play_o);
   cover property (ptr_fwd_o && msg_last_i);
endmodule // pbmc_ctrl_sva

bind pbmc_ctrl pbmc_ctrl_sva #(.HOLD_CYC(HOLD_CYC)) u_pbmc_ctrl_sva (.sys_clk_i, .rst_n_i, .play_button_n_i,
   .forward_button_n_i, .erase_button_n_i, .record_busy_i, .msg_first_i, .msg_last_i, .play_done_i,
   .clip_present_i, .play_start_o, .ptr_fwd_o, .erase_msg_o, .erase_all_o, .clip_play_o, .clip_sel_o,
   .led_o, .busy_o);

// ---- pbmc_mem_model.sv ----
/*
 memory manager model: message pointer, first/last flags, timed
 playback, clip and erase completion pulses.
 assumes one-cycle command pulses from pbmc_ctrl.
*/
`timescale 1ns/1ps

module pbmc_mem_model #(
   parameter PLAY_LEN = 40,
   parameter CLIP_LEN = 20,
   parameter ERASE_LEN = 10,
   parameter NMSG = 4
)
(
   // clock and reset
   input wire sys_clk_i,
   input wire rst_n_i,
   // commands
   input wire play_start_i,
   input wire play_stop_i,
   input wire ptr_fwd_i,
   input wire erase_msg_i,
   input wire erase_all_i,
   input wire clip_play_i,
   // status
   output wire msg_first_o,
   output wire msg_last_o,
   output wire play_done_o,
   output wire erase_done_o,
   output wire clip_done_o,
   output wire [3:0] ptr_o
);
   reg [3:0] ptr_ff, cnt_ff;
   reg [7:0] play_ff, clip_ff, ers_ff;
   reg all_ff;

   assign msg_first_o = ptr_ff == 4'h0;
   assign msg_last_o = ptr_ff == cnt_ff - 4'h1;
   assign play_done_o = play_ff == 8'h1;
   assign clip_done_o = clip_ff == 8'h1;
   assign erase_done_o = ers_ff == 8'h1;
   assign ptr_o = ptr_ff;

   always @(posedge sys_clk_i)
   begin
      if (!rst_n_i)
      begin
         ptr_ff <= 4'(NMSG - 1);
         cnt_ff <= 4'(NMSG);
         play_ff <= 8'h0;
         clip_ff <= 8'h0;
         ers_ff <= 8'h0;
         all_ff <= 1'b0;
      end
      else
      begin
         play_ff <= play_stop_i ? 8'h0 : play_start_i ? 8'(PLAY_LEN) : play_ff - (play_ff != 8'h0);
         clip_ff <= clip_play_i ? 8'(CLIP_LEN) : clip_ff - (clip_ff != 8'h0);
         ers_ff <= (erase_msg_i || erase_all_i) ? 8'(ERASE_LEN) : ers_ff - (ers_ff != 8'h0);
         if (erase_msg_i || erase_all_i)
            all_ff <= erase_all_i;
         if (ptr_fwd_i)
            ptr_ff <= msg_last_o ? 4'h0 : ptr_ff + 4'h1;
         // finished erase moves pointer to the new first or last message
         if (erase_done_o && all_ff)
         begin
            cnt_ff <= 4'h0;
            ptr_ff <= 4'h0;
         end
         else if (erase_done_o)
         begin
            cnt_ff <= cnt_ff - 4'h1;
            if (msg_last_o && !msg_first_o)
               ptr_ff <= ptr_ff - 4'h1;
         end
      end
   end
endmodule // pbmc_mem_model

// ---- tb.sv ----
/*
 self-checking bench for pbmc_ctrl with the memory manager model.
 assumes short simulation counts handed to the design parameters.
*/
`timescale 1ns/1ps

module tb;
   logic sys_clk, rst_n, rec_busy;
   logic [2:0] btn_n;
   logic [3:0] clips;
   wire m_first, m_last, p_done, e_done, c_done, led_o, busy_o;
   wire p_start, p_stop, p_fwd, e_msg, e_all, c_play;
   wire [1:0] clip_sel_o;
   wire [3:0] ptr;
   int n[7];
   logic led_q = 1'b0;
   int mismatches = 0;
   int cmp_count = 0;

   pbmc_ctrl #(.HOLD_CYC(200), .FLASH_CYC(4), .PLAIN_ONE_CYC(16), .PLAIN_THREE_CYC(16),
      .PLAIN_FOUR_CYC(16)) u_pbmc_ctrl (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .play_button_n_i(btn_n[0]),
      .forward_button_n_i(btn_n[1]), .erase_button_n_i(btn_n[2]), .record_busy_i(rec_busy),
      .msg_first_i(m_first), .msg_last_i(m_last), .play_done_i(p_done), .erase_done_i(e_done),
      .clip_present_i(clips), .clip_done_i(c_done), .play_start_o(p_start), .play_stop_o(p_stop),
      .ptr_fwd_o(p_fwd), .erase_msg_o(e_msg), .erase_all_o(e_all), .clip_play_o(c_play),
      .clip_sel_o(clip_sel_o), .led_o(led_o), .busy_o(busy_o));

   pbmc_mem_model u_pbmc_mem_model (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .play_start_i(p_start),
      .play_stop_i(p_stop), .ptr_fwd_i(p_fwd), .erase_msg_i(e_msg), .erase_all_i(e_all), .clip_play_i(c_play),
      .msg_first_o(m_first), .msg_last_o(m_last), .play_done_o(p_done), .erase_done_o(e_done),
      .clip_done_o(c_done), .ptr_o(ptr));

   initial
   begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // pulse and led-rise tallies: start, stop, fwd, erase, erase all, clip, led
   always @(posedge sys_clk)
   begin
      n[0] += p_start;
      n[1] += p_stop;
      n[2] += p_fwd;
      n[3] += e_msg;
      n[4] += e_all;
      n[5] += c_play;
      n[6] += (led_o && !led_q);
      led_q <= led_o;
   end

   task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t %s: seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task clr;
      foreach (n[i]) n[i] = 0;
   endtask

   task press(input int b, input int len);
      btn_n[b] = 1'b0;
      repeat (len) @(negedge sys_clk);
      btn_n[b] = 1'b1;
   endtask

   task wait_idle;
      int k;
      k = 0;
      repeat (8) @(negedge sys_clk);
      while (busy_o !== 1'b0 && k < 3000)
      begin
         @(negedge sys_clk);
         k++;
      end
      if (k == 3000) check(16'h1, 16'h0, "idle wait");
      repeat (4) @(negedge sys_clk);
   endtask

   task t_fwd(input logic [3:0] ep, input int blinks);
      clr;
      press(1, 4);
      wait_idle;
      check(n[2], 1, "forward pulses");
      check(ptr, ep, "pointer after forward");
      // blinks of zero: clip-timed flashing, at least one rise expected
      if (blinks > 0)
         check(n[6], blinks, "forward blinks");
      else
         check(n[6] != 0, 1, "clip flashing");
      $display("test forward done");
   endtask

   task t_erase_bad;
      clr;
      press(2, 4);
      wait_idle;
      check(n[3], 0, "refused erase");
      check(n[6], 3, "refusal blinks");
      check(ptr, 1, "pointer after refusal");
      $display("test erase refused done");
   endtask

   task t_play;
      clr;
      press(0, 4);
      repeat (15) @(negedge sys_clk);
      press(0, 4);
      wait_idle;
      check(n[1], 1, "play stop");
      check(ptr, 1, "pointer after stop");
      clr;
      press(0, 4);
      wait_idle;
      check(n[0], 1, "play start");
      check(n[1], 0, "self stop");
      check(n[6] != 0, 1, "flashing");
      check(led_o, 0, "led off");
      $display("test play done");
   endtask

   task t_loop;
      int k;
      clr;
      k = 0;
      btn_n[0] = 1'b0;
      while (ptr !== 4'h3 && k < 1000)
      begin
         @(negedge sys_clk);
         k++;
      end
      btn_n[0] = 1'b1;
      wait_idle;
      check(n[2], 2, "loop steps");
      check(n[0], 3, "loop plays");
      check(ptr, 3, "pointer after loop");
      $display("test loop done");
   endtask

   task t_erase_ok;
      clr;
      press(2, 4);
      wait_idle;
      check(n[3], 1, "erase last");
      check(n[6], 2, "erase blinks");
      check(ptr, 2, "new last");
      $display("test erase done");
   endtask

   task t_clip;
      clips = 4'hF;
      t_fwd(4'h0, 0);
      check(clip_sel_o, 2'h1, "wrap clip");
      check(n[5], 1, "clip played");
      t_fwd(4'h1, 0);
      check(clip_sel_o, 2'h0, "step clip");
      clips = 4'h0;
      $display("test clips done");
   endtask

   task t_busy;
      clr;
      rec_busy = 1'b1;
      press(1, 4);
      press(0, 4);
      repeat (10) @(negedge sys_clk);
      rec_busy = 1'b0;
      check(n[2], 0, "forward in record");
      check(n[0], 0, "play in record");
      $display("test record busy done");
   endtask

   task t_global;
      int k;
      clr;
      press(2, 215);
      wait_idle;
      check(n[4], 0, "abandoned erase");
      clr;
      k = 0;
      btn_n[2] = 1'b0;
      while (n[4] == 0 && k < 2000)
      begin
         @(negedge sys_clk);
         k++;
      end
      btn_n[2] = 1'b1;
      wait_idle;
      check(n[4], 1, "global erase");
      check(n[6], 10, "warning blinks");
      check(n[3], 0, "middle kept");
      $display("test global erase done");
   endtask

   task t_play_cmds;
      clr;
      press(0, 4);
      repeat (10) @(negedge sys_clk);
      press(1, 4);
      wait_idle;
      check(n[1], 1, "forward stops play");
      check(n[2], 1, "forward in play");
      check(n[0], 2, "new message played");
      check(ptr, 1, "pointer after play forward");
      clr;
      press(0, 4);
      repeat (10) @(negedge sys_clk);
      press(2, 4);
      wait_idle;
      check(n[1], 1, "erase stops play");
      check(n[3], 0, "middle kept in play");
      check(ptr, 1, "pointer after play erase");
      $display("test play commands done");
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      repeat (40000) @(posedge sys_clk);
      mismatches++;
      tally_and_finish;
   end

   initial
   begin
      rst_n = 1'b0;
      rec_busy = 1'b0;
      btn_n = 3'h7;
      clips = 4'h0;
      clr;
      repeat (5) @(negedge sys_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      t_fwd(4'h0, 2);
      t_fwd(4'h1, 1);
      t_erase_bad;
      t_play;
      t_loop;
      t_erase_ok;
      t_clip;
      t_busy;
      t_global;
      t_play_cmds;
      tally_and_finish;
   end
endmodule // tb
